// File: hdl/smc_serial_master.sv
// serial master with control and status registers behind a register port
// assumes the register port follows a two-phase select/enable handshake,
// and that tx_push, rx_pop come from logic on the same clock
//
// Operation
// - lane format bits 22:21 choose single, dual or quad lanes
// - wide frame length n gives data frames of n+1 serial clocks
// - control frame length n gives control frames of n+1 serial clocks
// - direction bits 9:8 pick duplex, tx only, rx only or read mode
// - bit 24 enables select toggling between frames, reset zero
// - bit 11 loops shift output back into shift input
// - 16-bit frame count sets frames transferred in counted modes
// - select bit 0 set asserts the one slave select line during frames
// - tx threshold sets level judging the tx empty condition
// - rx threshold sets level judging the rx full condition
// - status word holds seven flags, all zero after reset
// - six mask bits gate six event sources, reset zero
`timescale 1ns/1ps
`default_nettype none
module smc_serial_master
    import smc_pkg::*;
(
    // system
    input  wire logic        clock,
    input  wire logic        reset_n,
    // register port
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // data words
    input  wire logic        tx_push,
    input  wire logic [31:0] tx_word,
    input  wire logic        rx_pop,
    output logic      [31:0] rx_word,
    // serial pins
    output logic             sclk,
    output logic             ss_n,
    output logic      [3:0]  sd_out,
    output logic      [3:0]  sd_oe_n,
    input  wire logic [3:0]  sd_in,
    // masked event levels
    output logic      [5:0]  event_flags
);
    // registers
    logic [31:0]   ctrl0_reg;
    logic [31:0]   ctrl1_reg;
    logic          enable_reg;
    logic [2:0]    wire3_reg;
    logic          select_reg;
    logic [15:0]   divider_reg;
    logic [7:0]    tx_thr_reg;
    logic [7:0]    rx_thr_reg;
    logic [5:0]    mask_reg;
    // fifos
    logic [31:0]      tx_mem [FIFO_SIZE];
    logic [31:0]      rx_mem [FIFO_SIZE];
    logic [PTR_W-1:0] tx_wr_reg;
    logic [PTR_W-1:0] tx_rd_reg;
    logic [PTR_W-1:0] rx_wr_reg;
    logic [PTR_W-1:0] rx_rd_reg;
    logic [LVL_W-1:0] tx_lvl_reg;
    logic [LVL_W-1:0] rx_lvl_reg;
    // engine
    smc_state_type state_reg;
    logic          cur_tx_reg;
    logic          cur_rx_reg;
    logic [4:0]    cur_len_reg;
    logic [4:0]    clk_cnt_reg;
    logic [16:0]   rx_left_reg;
    logic [31:0]   tx_sh_reg;
    logic [31:0]   rx_sh_reg;
    // combinational
    logic [1:0]    lane_format;
    logic [1:0]    direction;
    logic          polarity;
    logic          multi_lane;
    logic [2:0]    lanes;
    logic          tick;
    logic          lead;
    logic          trail;
    logic          frame_end;
    logic          can_run;
    logic          start_rx;
    logic          start_tx;
    logic [4:0]    start_len;
    logic [7:0]    start_bits;
    logic [31:0]   tx_load;
    logic [3:0]    out_bits;
    logic [3:0]    in_bits;
    logic [3:0]    sd_in_sync;
    logic          tx_full;
    logic          rx_full;
    logic          tx_push_ok;
    logic          rx_push;
    logic          rx_push_ok;
    logic          rx_pop_ok;
    logic          setup;
    logic          wr_go;
    logic          rd_hit;
    logic [31:0]   rd_data;
    logic [6:0]    status;
    logic [5:0]    raw_events;

    assign lane_format = ctrl0_reg[CTL_LANE_LO +: 2];
    assign direction   = ctrl0_reg[CTL_DIR_LO +: 2];
    assign polarity    = ctrl0_reg[CTL_POL];
    assign multi_lane  = lane_format != LANE_SINGLE;

    always_comb begin
        if (lane_format == LANE_SINGLE) begin
            lanes = 3'h1;
        end else if (lane_format == LANE_DUAL) begin
            lanes = 3'h2;
        end else begin
            lanes = 3'h4;
        end
    end

    smc_sync #(
        .W (4)
    ) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in (sd_in),
        .sync_out (sd_in_sync)
    );

    smc_clkdiv u_div (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (state_reg == S_SHIFT || state_reg == S_GAP),
        .divisor (divider_reg),
        .tick    (tick)
    );

    // register port: access phase always completes
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pwrite & pready;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = RESET_VALUE;
        case (paddr)
            OFS_CTRL0:   rd_data = ctrl0_reg;
            OFS_CTRL1:   rd_data = ctrl1_reg;
            OFS_ENABLE:  rd_data = {31'h0, enable_reg};
            OFS_WIRE3:   rd_data = {29'h0, wire3_reg};
            OFS_SELECT:  rd_data = {31'h0, select_reg};
            OFS_DIVIDER: rd_data = {16'h0, divider_reg};
            OFS_TX_THR:  rd_data = {24'h0, tx_thr_reg};
            OFS_RX_THR:  rd_data = {24'h0, rx_thr_reg};
            OFS_TX_LVL:  rd_data = {27'h0, tx_lvl_reg};
            OFS_RX_LVL:  rd_data = {27'h0, rx_lvl_reg};
            OFS_STATUS:  rd_data = {25'h0, status};
            OFS_MASK:    rd_data = {26'h0, mask_reg};
            default:     rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rd_hit;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_data;
            end
        end
    end

    // masks drop reserved bits on the way in
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl0_reg   <= RESET_VALUE;
            ctrl1_reg   <= RESET_VALUE;
            enable_reg  <= 1'b0;
            wire3_reg   <= 3'h0;
            select_reg  <= 1'b0;
            divider_reg <= 16'h0000;
            tx_thr_reg  <= 8'h00;
            rx_thr_reg  <= 8'h00;
            mask_reg    <= 6'h00;
        end else if (wr_go && !pslverr) begin
            case (paddr)
                OFS_CTRL0:   ctrl0_reg   <= pwdata & MASK_CTRL0;
                OFS_CTRL1:   ctrl1_reg   <= pwdata & MASK_CTRL1;
                OFS_ENABLE:  enable_reg  <= pwdata[0];
                OFS_WIRE3:   wire3_reg   <= pwdata[2:0];
                OFS_SELECT:  select_reg  <= pwdata[0];
                OFS_DIVIDER: divider_reg <= pwdata[15:0];
                OFS_TX_THR:  tx_thr_reg  <= pwdata[7:0];
                OFS_RX_THR:  rx_thr_reg  <= pwdata[7:0];
                OFS_MASK:    mask_reg    <= pwdata[5:0];
                default:     ctrl0_reg   <= ctrl0_reg;
            endcase
        end
    end

    // fifo control; disabling flushes both sides
    assign tx_full    = tx_lvl_reg == LVL_FULL;
    assign rx_full    = rx_lvl_reg == LVL_FULL;
    assign tx_push_ok = tx_push & ~tx_full & enable_reg;
    assign rx_push    = frame_end & cur_rx_reg;
    assign rx_push_ok = rx_push & ~rx_full;
    assign rx_pop_ok  = rx_pop & (rx_lvl_reg != 5'h00);

    always_ff @(posedge clock) begin
        if (tx_push_ok) begin
            tx_mem[tx_wr_reg] <= tx_word;
        end
        if (rx_push_ok) begin
            rx_mem[rx_wr_reg] <= rx_sh_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_wr_reg  <= '0;
            tx_rd_reg  <= '0;
            tx_lvl_reg <= '0;
        end else if (!enable_reg) begin
            tx_wr_reg  <= '0;
            tx_rd_reg  <= '0;
            tx_lvl_reg <= '0;
        end else begin
            if (tx_push_ok) begin
                tx_wr_reg <= tx_wr_reg + 1'b1;
            end
            if (start_tx) begin
                tx_rd_reg <= tx_rd_reg + 1'b1;
            end
            case ({tx_push_ok, start_tx})
                2'b10:   tx_lvl_reg <= tx_lvl_reg + 1'b1;
                2'b01:   tx_lvl_reg <= tx_lvl_reg - 1'b1;
                default: tx_lvl_reg <= tx_lvl_reg;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_wr_reg  <= '0;
            rx_rd_reg  <= '0;
            rx_lvl_reg <= '0;
            rx_word    <= 32'h00000000;
        end else if (!enable_reg) begin
            rx_wr_reg  <= '0;
            rx_rd_reg  <= '0;
            rx_lvl_reg <= '0;
        end else begin
            if (rx_push_ok) begin
                rx_wr_reg <= rx_wr_reg + 1'b1;
            end
            if (rx_pop_ok) begin
                rx_rd_reg <= rx_rd_reg + 1'b1;
                rx_word   <= rx_mem[rx_rd_reg];
            end
            case ({rx_push_ok, rx_pop_ok})
                2'b10:   rx_lvl_reg <= rx_lvl_reg + 1'b1;
                2'b01:   rx_lvl_reg <= rx_lvl_reg - 1'b1;
                default: rx_lvl_reg <= rx_lvl_reg;
            endcase
        end
    end

    // frame start decision
    assign can_run  = enable_reg & (divider_reg != 16'h0000);
    assign start_rx = (state_reg == S_IDLE || state_reg == S_HOLD) & can_run
                      & (rx_left_reg != 17'h00000) & ~rx_full;
    // counted modes end the transaction; duplex and tx-only keep streaming
    assign start_tx = (state_reg == S_IDLE || state_reg == S_HOLD) & can_run
                      & (rx_left_reg == 17'h00000) & (tx_lvl_reg != 5'h00)
                      & (state_reg == S_IDLE || direction == DIR_TXRX
                         || direction == DIR_TX);
    assign start_len = (direction == DIR_READ)
                       ? {1'b0, ctrl0_reg[CTL_CLEN_LO +: 4]}
                       : ctrl0_reg[CTL_FLEN_LO +: 5];
    assign start_bits = ({3'h0, start_len} + 8'h01) * {5'h00, lanes};
    assign tx_load    = (start_bits >= WORD_BITS) ? tx_mem[tx_rd_reg]
                        : tx_mem[tx_rd_reg] << (WORD_BITS - start_bits);

    assign lead      = tick & (sclk == polarity);
    assign trail     = tick & (sclk != polarity);
    assign frame_end = (state_reg == S_SHIFT) & trail
                       & (clk_cnt_reg == cur_len_reg);

    always_comb begin
        if (lane_format == LANE_SINGLE) begin
            out_bits = {3'h0, tx_sh_reg[31]};
            in_bits  = {3'h0, sd_in_sync[1]};
        end else if (lane_format == LANE_DUAL) begin
            out_bits = {2'h0, tx_sh_reg[31:30]};
            in_bits  = {2'h0, sd_in_sync[1:0]};
        end else begin
            out_bits = tx_sh_reg[31:28];
            in_bits  = sd_in_sync;
        end
        if (ctrl0_reg[CTL_LOOP]) begin
            in_bits = out_bits;
        end
    end

    // serial engine
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= S_IDLE;
            sclk        <= 1'b0;
            cur_tx_reg  <= 1'b0;
            cur_rx_reg  <= 1'b0;
            cur_len_reg <= 5'h00;
            clk_cnt_reg <= 5'h00;
            rx_left_reg <= 17'h00000;
            tx_sh_reg   <= 32'h00000000;
            rx_sh_reg   <= 32'h00000000;
        end else if (!enable_reg) begin
            state_reg   <= S_IDLE;
            sclk        <= polarity;
            rx_left_reg <= 17'h00000;
        end else begin
            case (state_reg)
                S_IDLE, S_HOLD: begin
                    sclk        <= polarity;
                    clk_cnt_reg <= 5'h00;
                    rx_sh_reg   <= 32'h00000000;
                    if (start_rx) begin
                        state_reg   <= S_SHIFT;
                        cur_tx_reg  <= 1'b0;
                        cur_rx_reg  <= 1'b1;
                        cur_len_reg <= ctrl0_reg[CTL_FLEN_LO +: 5];
                        rx_left_reg <= rx_left_reg - 17'h00001;
                    end else if (start_tx) begin
                        state_reg   <= S_SHIFT;
                        cur_tx_reg  <= direction != DIR_RX;
                        cur_rx_reg  <= direction == DIR_TXRX || direction == DIR_RX;
                        cur_len_reg <= start_len;
                        tx_sh_reg   <= tx_load;
                        if (direction == DIR_RX) begin
                            rx_left_reg <= {1'b0, ctrl1_reg[15:0]};
                        end else if (direction == DIR_READ) begin
                            rx_left_reg <= {1'b0, ctrl1_reg[15:0]} + 17'h00001;
                        end
                    end else if (state_reg == S_HOLD) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_SHIFT: begin
                    if (tick) begin
                        sclk <= ~sclk;
                    end
                    if (lead && cur_rx_reg) begin
                        rx_sh_reg <= (rx_sh_reg << lanes) | {28'h0, in_bits};
                    end
                    if (trail) begin
                        tx_sh_reg   <= tx_sh_reg << lanes;
                        clk_cnt_reg <= clk_cnt_reg + 5'h01;
                    end
                    if (frame_end) begin
                        state_reg <= ctrl0_reg[CTL_TOGGLE] ? S_GAP : S_HOLD;
                    end
                end
                S_GAP: begin
                    sclk <= polarity;
                    if (tick) begin
                        state_reg <= S_HOLD;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // pins; rx frames release the data lanes in multi-lane formats
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ss_n    <= 1'b1;
            sd_out  <= 4'h0;
            sd_oe_n <= 4'hF;
        end else begin
            ss_n   <= ~(select_reg & (state_reg == S_SHIFT || state_reg == S_HOLD));
            sd_out <= cur_tx_reg ? out_bits : 4'h0;
            if (state_reg == S_SHIFT && (cur_tx_reg || !multi_lane)) begin
                sd_oe_n <= ~((4'h1 << lanes) - 4'h1);
            end else begin
                sd_oe_n <= 4'hF;
            end
        end
    end

    // status and events; collision and transmit error never arise in a lone master
    // flags read zero while disabled, so the word is clear out of reset
    assign status = !enable_reg ? 7'h00
                    : {1'b0, 1'b0, rx_full, rx_lvl_reg != 5'h00, tx_lvl_reg == 5'h00,
                       ~tx_full, state_reg != S_IDLE};
    assign raw_events = {1'b0,
                         {3'h0, rx_lvl_reg} > rx_thr_reg,
                         rx_push & rx_full,
                         rx_pop & (rx_lvl_reg == 5'h00),
                         tx_push & tx_full & enable_reg,
                         {3'h0, tx_lvl_reg} <= tx_thr_reg};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            event_flags <= 6'h00;
        end else begin
            event_flags <= raw_events & mask_reg;
        end
    end
endmodule
`default_nettype wire

// File: hdl/smc_pkg.sv
// constants for the serial master control block: offsets, field layout, codes
// assumes a byte address of eight bits with word-aligned registers
package smc_pkg;

    // register offsets
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_ENABLE  = 8'h08;
    localparam logic [7:0] OFS_WIRE3   = 8'h0C;
    localparam logic [7:0] OFS_SELECT  = 8'h10;
    localparam logic [7:0] OFS_DIVIDER = 8'h14;
    localparam logic [7:0] OFS_TX_THR  = 8'h18;
    localparam logic [7:0] OFS_RX_THR  = 8'h1C;
    localparam logic [7:0] OFS_TX_LVL  = 8'h20;
    localparam logic [7:0] OFS_RX_LVL  = 8'h24;
    localparam logic [7:0] OFS_STATUS  = 8'h28;
    localparam logic [7:0] OFS_MASK    = 8'h2C;

    // writable bits of each register
    localparam logic [31:0] MASK_CTRL0   = 32'h017FFFFF;
    localparam logic [31:0] MASK_CTRL1   = 32'h0000FFFF;
    localparam logic [31:0] MASK_ENABLE  = 32'h00000001;
    localparam logic [31:0] MASK_WIRE3   = 32'h00000007;
    localparam logic [31:0] MASK_SELECT  = 32'h00000001;
    localparam logic [31:0] MASK_DIVIDER = 32'h0000FFFF;
    localparam logic [31:0] MASK_THR     = 32'h000000FF;
    localparam logic [31:0] MASK_IRQ     = 32'h0000003F;
    localparam logic [31:0] RESET_VALUE  = 32'h00000000;

    // control word zero field positions
    localparam int CTL_TOGGLE  = 24;
    localparam int CTL_LANE_LO = 21;
    localparam int CTL_FLEN_LO = 16;
    localparam int CTL_CLEN_LO = 12;
    localparam int CTL_LOOP    = 11;
    localparam int CTL_DIR_LO  = 8;
    localparam int CTL_POL     = 7;

    // lane formats and transfer directions
    localparam logic [1:0] LANE_SINGLE = 2'h0;
    localparam logic [1:0] LANE_DUAL   = 2'h1;
    localparam logic [1:0] DIR_TXRX    = 2'h0;
    localparam logic [1:0] DIR_TX      = 2'h1;
    localparam logic [1:0] DIR_RX      = 2'h2;
    localparam logic [1:0] DIR_READ    = 2'h3;

    // fifo geometry
    localparam int              PTR_W     = 4;
    localparam int              LVL_W     = 5;
    localparam int              FIFO_SIZE = 16;
    localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;

    // frame arithmetic
    localparam logic [7:0] WORD_BITS = 8'h20;

    typedef enum logic [1:0] {S_IDLE, S_HOLD, S_GAP, S_SHIFT} smc_state_type;

endpackage

// File: hdl/smc_sync.sv
// two-stage synchroniser for pin inputs
// assumes the inputs are quasi-static against clock
`timescale 1ns/1ps
`default_nettype none
module smc_sync #(
    parameter int W = 4
) (
    // system
    input  wire logic         clock,
    input  wire logic         reset_n,
    // pins in, synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// File: hdl/smc_clkdiv.sv
// half-period tick generator for the serial clock
// assumes divisor is stable while run is high
`timescale 1ns/1ps
`default_nettype none
module smc_clkdiv (
    // system
    input  wire logic        clock,
    input  wire logic        reset_n,
    // control
    input  wire logic        run,
    input  wire logic [15:0] divisor,
    // one-cycle pulse per half serial period
    output logic             tick
);
    logic [14:0] half;
    logic [14:0] count_reg;

    // odd divisors round down; a divisor of one still gives a tick
    assign half = (divisor[15:1] == 15'h0000) ? 15'h0001 : divisor[15:1];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 15'h0000;
            tick      <= 1'b0;
        end else if (!run) begin
            count_reg <= 15'h0000;
            tick      <= 1'b0;
        end else if (count_reg >= half - 15'h0001) begin
            count_reg <= 15'h0000;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 15'h0001;
            tick      <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verif/smc_serial_master_asserts.sv
// checker for the register port and pins of the serial master
// assumes one clock domain and binding onto smc_serial_master
`timescale 1ns/1ps
`default_nettype none
module smc_serial_master_asserts (
    // system
    input wire logic        clock,
    input wire logic        reset_n,
    // register port
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and events
    input wire logic        ss_n,
    input wire logic [3:0]  sd_oe_n,
    input wire logic [5:0]  event_flags
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
        else $error("ready without a setup cycle");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h2C |=> pslverr)
        else $error("unmapped address not refused");
    AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_PRDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed without a setup");
    AST_CONTENTION_ZERO: assert property (event_flags[5] == 1'b0)
        else $error("contention event raised by a single master");
    AST_RESET_IDLE: assert property ($rose(reset_n) |-> ss_n && sd_oe_n == 4'hF)
        else $error("pins not idle after reset");
endmodule

bind smc_serial_master smc_serial_master_asserts u_asserts (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ss_n(ss_n), .sd_oe_n(sd_oe_n), .event_flags(event_flags));
`default_nettype wire

// File: verif/smc_slave_model.sv
// behavioural serial slave: answers ones on every lane it owns
// assumes lanes the master releases are resolved here
`timescale 1ns/1ps
`default_nettype none
module smc_slave_model (
    // pins from the master
    input  wire logic       clock,
    input  wire logic       ss_n,
    input  wire logic [3:0] sd_out,
    input  wire logic [3:0] sd_oe_n,
    // resolved lane levels
    output logic      [3:0] sd_in
);
    logic [3:0] drive_reg = 4'h5;

    // no pull-ups, so a deselected lane wanders every cycle
    always_ff @(posedge clock) begin
        drive_reg <= ss_n ? ~drive_reg : 4'hF;
    end
    assign sd_in = (sd_out & ~sd_oe_n) | (drive_reg & sd_oe_n);
endmodule
`default_nettype wire

// File: verif/smc_serial_master_tb_top.sv
// self-checking bench for the serial master: registers, events, frames
// assumes the slave model answers ones on every lane it owns
`timescale 1ns/1ps
`default_nettype none
module smc_serial_master_tb_top;
    import smc_pkg::*;
    logic        clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        tx_push = 0, rx_pop = 0, pop_d = 0, sclk_d = 0, pready, pslverr, sclk, ss_n;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, tx_word = 0, prdata, rx_word, w;
    logic [3:0]  sd_out, sd_oe_n, sd_in;
    logic [5:0]  event_flags;
    logic [31:0] exp_q[$];
    logic [31:0] masks[12] = '{MASK_CTRL0, MASK_CTRL1, MASK_ENABLE, MASK_WIRE3,
        MASK_SELECT, MASK_DIVIDER, MASK_THR, MASK_THR, 0, 0, 0, MASK_IRQ};
    int          miscompares = 0, n_compared = 0, cycles = 0, edges = 0;

    initial forever #5 clock = ~clock;
    smc_serial_master u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_push(tx_push),
        .tx_word(tx_word), .rx_pop(rx_pop), .rx_word(rx_word), .sclk(sclk),
        .ss_n(ss_n), .sd_out(sd_out), .sd_oe_n(sd_oe_n), .sd_in(sd_in),
        .event_flags(event_flags));
    smc_slave_model u_slave (.clock(clock), .ss_n(ss_n), .sd_out(sd_out),
        .sd_oe_n(sd_oe_n), .sd_in(sd_in));

    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // setup, access, release; address and data held throughout
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input logic push, input logic [31:0] d);
        @(posedge clock);
        tx_push <= push;
        rx_pop  <= !push;
        tx_word <= d;
        @(posedge clock);
        tx_push <= 1'b0;
        rx_pop  <= 1'b0;
    endtask
    task automatic pop(input logic [31:0] e);
        exp_q.push_back(e);
        pulse(1'b0, 32'h0);
    endtask
    // config only while disabled; disabling clears the fifos
    task automatic frame(input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] d);
        wr(OFS_ENABLE, 32'h0);
        wr(OFS_CTRL0, c0);
        wr(OFS_CTRL1, c1);
        wr(OFS_ENABLE, 32'h1);
        pulse(1'b1, d);
        wait (!ss_n);
        wait (ss_n);
        repeat (4) @(posedge clock);
    endtask

    // results: read data with ready, popped word one edge after the pop
    always @(posedge clock) begin
        pop_d <= rx_pop;
        sclk_d <= sclk;
        if (sclk && !sclk_d && !ss_n)
            edges++;
        cycles++;
        if ((pready && !pwrite) || pop_d)
            chk(pready ? prdata : rx_word, exp_q.pop_front());
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        w = $urandom(32'h82ae);
        w = $urandom() & 32'hFFFFFFFE;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        for (int a = 0; a < 'h30; a += 4) rd(8'(a), 32'h0);
        for (int a = 0; a < 'h30; a += 4) wr(8'(a), w);
        for (int a = 0; a < 'h30; a += 4) if (a != 'h28) rd(8'(a), w & masks[a/4]);
        rd(8'h30, 32'h0);
        wr(OFS_TX_THR, 32'h0);
        wr(OFS_RX_THR, 32'h0);
        wr(OFS_MASK, 32'h3F);
        pulse(1'b1, w);
        #1 chk(32'(event_flags), 32'h1);
        pop(32'h0);
        #1 chk(32'(event_flags), 32'h5);
        // divider zero keeps the engine idle, so the fifo fills up
        wr(OFS_DIVIDER, 32'h0);
        wr(OFS_ENABLE, 32'h1);
        for (int i = 0; i < 17; i++) pulse(1'b1, w);
        #1 chk(32'(event_flags), 32'h2);
        rd(OFS_TX_LVL, 32'h10);
        wr(OFS_ENABLE, 32'h0);
        wr(OFS_MASK, 32'h0);
        wr(OFS_DIVIDER, 32'h8);
        wr(OFS_SELECT, 32'h1);
        w = $urandom();
        frame(32'h001F0800, 32'h0, w);
        chk(edges, 32'h20);
        rd(OFS_RX_LVL, 32'h1);
        pop(w);
        // receive-only kept to a multi-lane format
        frame(32'h00430200, 32'h2, w);
        rd(OFS_RX_LVL, 32'h3);
        rd(OFS_STATUS, 32'hE);
        wr(OFS_MASK, 32'h10);
        @(posedge clock) #1 chk(32'(event_flags), 32'h10);
        chk(edges, 32'h2C);
        for (int i = 0; i < 3; i++) pop(32'h0000FFFF);
        frame(32'h00237300, 32'h0, w);
        chk(edges, 32'h38);
        rd(OFS_TX_LVL, 32'h0);
        pop(32'h000000FF);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule
`default_nettype wire
